// ---- bench/clock_source_model.sv ----
`timescale 1ns/1ps

module clock_source_model (
	// controls
	input wire logic pll_enable,
	input wire logic osc_run,
	// clock pins
	output logic crystal_input,
	output logic pll_ref_clk
);
	// crystal clock, stands still while stopped
	initial begin
		crystal_input = 1'b0;
		forever #430 if (osc_run) crystal_input = ~crystal_input;
	end
	// own reference, no tie to the crystal; idle while disabled
	initial begin
		pll_ref_clk = 1'b0;
		forever #530 if (pll_enable) pll_ref_clk = ~pll_ref_clk;
	end
endmodule : clock_source_model

// ---- bench/osc_power_checker.sv ----
`timescale 1ns/1ps
`include "osc_monitor_defines.svh"

module osc_power_checker (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// watched inputs
	input wire logic rd_strobe_n,
	input wire osc_monitor_pkg::peripheral_mgmt_s peripheral_mgmt_reg,
	// watched outputs
	input wire logic cpu_clk_tick,
	input wire logic periph_clk_tick,
	input wire logic [`PERIPH_N-1:0] periph_clk_en,
	input wire logic monitor_disable,
	input wire logic clock_fallback,
	input wire logic monitor_irq,
	input wire logic pll_enable,
	input wire logic cpu_halted,
	input wire logic clocks_stopped
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// interrupt comes with the switch-over
	AST_IRQ_FALLBACK: assert property ($rose(monitor_irq) |-> $rose(clock_fallback))
		else $error("interrupt without fallback");
	AST_FALLBACK_PLL: assert property ($rose(clock_fallback) |=> pll_enable)
		else $error("fallback without pll");
	AST_STICKY: assert property (clock_fallback |=> clock_fallback)
		else $error("fallback dropped");
	AST_DIS_IRQ: assert property (monitor_disable |-> !monitor_irq)
		else $error("interrupt while disabled");
	AST_DIS_PLL: assert property (monitor_disable && !clock_fallback |-> !pll_enable)
		else $error("pll running while disabled");
	AST_STRAP: assert property ($fell(reset) |-> monitor_disable == !rd_strobe_n)
		else $error("strap not inverted");
	AST_STOP: assert property (clocks_stopped |-> cpu_halted && periph_clk_en == '0)
		else $error("clocks run while stopped");
	AST_STOP_TICKS: assert property (clocks_stopped [*4] |-> !cpu_clk_tick && !periph_clk_tick)
		else $error("tick while stopped");
	AST_IDLE: assert property (cpu_halted [*4] |-> !cpu_clk_tick)
		else $error("cpu tick while halted");
	AST_GROUP: assert property (!$past(reset) && !clocks_stopped |->
		periph_clk_en == ($past(peripheral_mgmt_reg.enable) &
		~($past(peripheral_mgmt_reg.group_disable) ? `PERIPH_GROUP_MASK : 16'h0000)))
		else $error("peripheral enables wrong");
endmodule : osc_power_checker

bind oscillator_monitor_power_control osc_power_checker u_chk (.clk_sys(clk_sys),
	.reset(reset), .rd_strobe_n(rd_strobe_n), .peripheral_mgmt_reg(peripheral_mgmt_reg),
	.cpu_clk_tick(cpu_clk_tick), .periph_clk_tick(periph_clk_tick),
	.periph_clk_en(periph_clk_en), .monitor_disable(monitor_disable),
	.clock_fallback(clock_fallback), .monitor_irq(monitor_irq), .pll_enable(pll_enable),
	.cpu_halted(cpu_halted), .clocks_stopped(clocks_stopped));

// ---- bench/oscillator_monitor_power_control_tb_top.sv ----
`timescale 1ns/1ps
`include "osc_monitor_defines.svh"

module oscillator_monitor_power_control_tb_top;
	logic clk_sys, reset, crystal_input, pll_ref_clk, rd_strobe_n, ext_irq, monitor_disable_set;
	osc_monitor_pkg::clock_mgmt_s clock_mgmt_reg;
	osc_monitor_pkg::peripheral_mgmt_s peripheral_mgmt_reg;
	osc_monitor_pkg::power_cmd_s power_cmd;
	logic irq_pending, rtc_enable, rtc_keep_run, osc_run;
	logic [15:0] rtc_period, periph_clk_en;
	logic cpu_clk_tick, periph_clk_tick, monitor_disable, clock_fallback, monitor_irq;
	logic pll_enable, cpu_halted, clocks_stopped, rtc_running, rtc_wake;
	logic [31:0] r, seed; // random draw and seed
	logic [7:0] cfg [5] = '{8'h00, 8'h02, 8'h81, 8'h8A, 8'hFC}; // clock settings
	logic [1:0] exp_q [$]; // expected {irq, wake} events
	int failures, total_checks, n, m;

	oscillator_monitor_power_control dut (.clk_sys(clk_sys), .reset(reset),
		.crystal_input(crystal_input), .pll_ref_clk(pll_ref_clk), .rd_strobe_n(rd_strobe_n),
		.ext_irq(ext_irq), .monitor_disable_set(monitor_disable_set),
		.clock_mgmt_reg(clock_mgmt_reg), .peripheral_mgmt_reg(peripheral_mgmt_reg),
		.power_cmd(power_cmd), .irq_pending(irq_pending), .rtc_enable(rtc_enable),
		.rtc_keep_run(rtc_keep_run), .rtc_period(rtc_period), .cpu_clk_tick(cpu_clk_tick),
		.periph_clk_tick(periph_clk_tick), .periph_clk_en(periph_clk_en),
		.monitor_disable(monitor_disable), .clock_fallback(clock_fallback),
		.monitor_irq(monitor_irq), .pll_enable(pll_enable), .cpu_halted(cpu_halted),
		.clocks_stopped(clocks_stopped), .rtc_running(rtc_running), .rtc_wake(rtc_wake));
	clock_source_model u_src (.pll_enable(pll_enable), .osc_run(osc_run),
		.crystal_input(crystal_input), .pll_ref_clk(pll_ref_clk));

	// system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict

	// reset with strap level held stable
	task do_reset(input logic rd);
		rd_strobe_n <= rd;
		reset <= 1'b1;
		repeat (6) @(posedge clk_sys);
		reset <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask : do_reset

	task pulse(input logic [2:0] c);
		@(posedge clk_sys) power_cmd <= c;
		@(posedge clk_sys) power_cmd <= 3'h0;
		repeat (3) @(posedge clk_sys);
	endtask : pulse

	// cpu ticks over 100 crystal half-period pairs, within one of the ideal count
	task count_ticks(input int div, input int half_ns);
		n = 0;
		repeat (2150) @(posedge clk_sys) n += (cpu_clk_tick === 1'b1);
		n = n - 43000 / half_ns / div;
		check(n >= -1 && n <= 1, 1'b1);
	endtask : count_ticks

	// event watcher: each irq or wake from sleep takes the oldest note
	always @(posedge clk_sys) begin
		if (monitor_irq === 1'b1 || (rtc_wake === 1'b1 && clocks_stopped === 1'b1)) begin
			if (exp_q.size() == 0) check(1'b1, 1'b0);
			else check({monitor_irq, rtc_wake}, exp_q.pop_front());
		end
	end

	// hang guard
	initial begin
		#1600000;
		failures++;
		give_verdict();
	end

	initial begin
		{reset, rd_strobe_n, ext_irq, monitor_disable_set, irq_pending} = 5'h18;
		{rtc_enable, rtc_keep_run, rtc_period, power_cmd} = '0;
		clock_mgmt_reg = '0;
		peripheral_mgmt_reg = '0;
		osc_run = 1'b1;
		seed = 32'h4954402B;
		do_reset(1'b1);
		check(monitor_disable, 1'b0);
		check(pll_enable, 1'b1);
		// random peripheral enables and group bit
		repeat (6) begin
			r = $random(seed);
			peripheral_mgmt_reg <= r[16:0];
			repeat (3) @(posedge clk_sys);
			check(periph_clk_en, r[16:1] & ~(r[0] ? `PERIPH_GROUP_MASK : 16'h0000));
		end
		// direct, prescaler and slow-down rates
		foreach (cfg[i]) begin
			clock_mgmt_reg <= cfg[i];
			repeat (60) @(posedge clk_sys);
			if (cfg[i][0]) check(pll_enable, 1'b0);
			count_ticks((cfg[i][7] ? cfg[i][6:2] + 1 : 1) * (cfg[i][1] ? 2 : 1), 430);
		end
		// oscillator stops: switch to reference clock
		clock_mgmt_reg <= 8'h00;
		osc_run <= 1'b0;
		exp_q.push_back(2'b10);
		repeat (700) @(posedge clk_sys);
		check(clock_fallback, 1'b1);
		count_ticks(1, 530);
		clock_mgmt_reg <= 8'h02;
		repeat (60) @(posedge clk_sys);
		count_ticks(2, 530);
		osc_run <= 1'b1;
		repeat (100) @(posedge clk_sys);
		check(clock_fallback, 1'b1);
		do_reset(1'b1);
		check(clock_fallback, 1'b0);
		// software disable, then a missing oscillator stays silent
		clock_mgmt_reg <= 8'h00;
		@(posedge clk_sys) monitor_disable_set <= 1'b1;
		@(posedge clk_sys) monitor_disable_set <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check(pll_enable, 1'b0);
		osc_run <= 1'b0;
		repeat (700) @(posedge clk_sys);
		check(clock_fallback, 1'b0);
		osc_run <= 1'b1;
		count_ticks(1, 430);
		do_reset(1'b0);
		check(monitor_disable, 1'b1);
		// idle: cpu halted, peripherals ticking, pending irq wakes
		pulse(3'h4);
		m = 0;
		repeat (200) @(posedge clk_sys) m += (periph_clk_tick === 1'b1);
		check({cpu_halted, clocks_stopped, m > 0}, 3'h5);
		irq_pending <= 1'b1;
		repeat (3) @(posedge clk_sys) irq_pending <= 1'b0;
		check(cpu_halted, 1'b0);
		// sleep left by external interrupt
		pulse(3'h2);
		check(clocks_stopped, 1'b1);
		// held long enough to pass the pin filter
		ext_irq <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ext_irq <= 1'b0;
		repeat (6) @(posedge clk_sys);
		check({cpu_halted, clocks_stopped}, 2'b00);
		// sleep left by the wakeup timer, which keeps running
		{rtc_enable, rtc_keep_run, rtc_period} <= {2'b11, 16'h0013};
		exp_q.push_back(2'b01);
		pulse(3'h2);
		check(rtc_running, 1'b1);
		repeat (25) @(posedge clk_sys);
		rtc_enable <= 1'b0;
		check(cpu_halted, 1'b0);
		// power-down ignores interrupts until reset
		pulse(3'h1);
		{ext_irq, irq_pending} <= 2'b11;
		repeat (4) @(posedge clk_sys);
		{ext_irq, irq_pending} <= 2'b00;
		repeat (6) @(posedge clk_sys);
		check(clocks_stopped, 1'b1);
		do_reset(1'b1);
		check({clocks_stopped, monitor_disable, exp_q.size() == 0}, 3'h1);
		give_verdict();
	end
endmodule : oscillator_monitor_power_control_tb_top

// ---- inc/osc_monitor_defines.svh ----
`ifndef OSC_MONITOR_DEFINES_SVH
`define OSC_MONITOR_DEFINES_SVH

// reference edges without an oscillator edge before the oscillator counts as missing
`define OSC_MISS_LIMIT 8'h10
// width of the missing-edge counter
`define MISS_W 8
// width of the slow-down factor field, factor minus one
`define SDD_W 5
// number of peripheral modules under individual control
`define PERIPH_N 16
// peripherals switched off together by the group-control bit
`define PERIPH_GROUP_MASK 16'h0FF0
// width of the wakeup period counter
`define RTC_W 16
// divide-by-one and divide-by-two settings of a tick divider
`define DIV_BY_1_M1 5'h00
`define DIV_BY_2_M1 5'h01
// reset values
`define MISS_RST 8'h00
`define RTC_RST 16'h0000
`define PERIPH_EN_RST 16'h0000

`endif

// ---- inc/osc_monitor_pkg.sv ----
`include "osc_monitor_defines.svh"

package osc_monitor_pkg;

	// power state, one-hot
	typedef enum logic [3:0] {
		PS_RUN = 4'h1,
		PS_IDLE = 4'h2,
		PS_SLEEP = 4'h4,
		PS_PDOWN = 4'h8
	} power_state_e;

	// clock generation management fields
	typedef struct packed {
		logic sdd_enable;
		logic [`SDD_W-1:0] sdd_factor_m1;
		logic prescaler_mode;
		logic pll_off_req;
	} clock_mgmt_s;

	// peripheral management fields
	typedef struct packed {
		logic [`PERIPH_N-1:0] enable;
		logic group_disable;
	} peripheral_mgmt_s;

	// power saving commands, one-cycle pulses
	typedef struct packed {
		logic idle;
		logic sleep;
		logic pdown;
	} power_cmd_s;

endpackage : osc_monitor_pkg

// ---- rtl/oscillator_monitor_power_control.sv ----
// Behaviour
// - missing oscillator raises interrupt, selects PLL clock
// - supervision reference comes from PLL, not crystal
// - direct drive fallback uses PLL base undivided
// - prescaler mode fallback divides PLL base by two
// - fallback clock held until hardware reset
// - monitor disabled before any fallback: PLL idle, oscillator drives CPU
// - monitor disabled: no interrupt on missing oscillator
// - disable bit takes inverted read strobe at reset
// - idle halts CPU, peripherals keep running
// - sleep and power-down stop clocks, RTC optional
// - external interrupt ends sleep mode
// - slow-down divides oscillator by 1 to 32
// - PLL may be switched off during slow-down
// - each peripheral individually enabled or disabled
// - one group bit disables major peripheral part
// - RTC produces cyclic wakeups from sleep
`timescale 1ns/1ps
`include "osc_monitor_defines.svh"

module oscillator_monitor_power_control (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// clock pins from outside this domain
	input wire logic crystal_input,
	input wire logic pll_ref_clk,
	// strap and external interrupt pins
	input wire logic rd_strobe_n,
	input wire logic ext_irq,
	// system configuration control
	input wire logic monitor_disable_set,
	// clock management control
	input wire osc_monitor_pkg::clock_mgmt_s clock_mgmt_reg,
	// peripheral management control
	input wire osc_monitor_pkg::peripheral_mgmt_s peripheral_mgmt_reg,
	// power saving commands and pending interrupt
	input wire osc_monitor_pkg::power_cmd_s power_cmd,
	input wire logic irq_pending,
	// wakeup timer control
	input wire logic rtc_enable,
	input wire logic rtc_keep_run,
	input wire logic [`RTC_W-1:0] rtc_period,
	// clock ticks
	output logic cpu_clk_tick,
	output logic periph_clk_tick,
	output logic [`PERIPH_N-1:0] periph_clk_en,
	// monitor status
	output logic monitor_disable,
	output logic clock_fallback,
	output logic monitor_irq,
	output logic pll_enable,
	// power status
	output logic cpu_halted,
	output logic clocks_stopped,
	output logic rtc_running,
	output logic rtc_wake
);

	// three-stage synchronisers, bit 0 is the first stage
	logic [2:0] osc_sync;
	logic [2:0] pll_sync;
	logic [2:0] rd_sync;
	logic [2:0] xirq_sync;
	// filtered levels and their previous values
	logic osc_level;
	logic osc_prev;
	logic pll_level;
	logic pll_prev;
	logic rd_level;
	logic xirq_level;
	logic xirq_prev;
	// rising edges of the filtered levels
	logic osc_edge;
	logic pll_edge;
	logic xirq_edge;

	// monitor state
	logic [`MISS_W-1:0] miss_cnt; // reference edges since last oscillator edge
	logic [`MISS_W-1:0] next_miss_cnt;
	logic next_monitor_disable;
	logic next_clock_fallback;
	logic next_monitor_irq;
	logic mon_active; // supervision armed

	// power state machine
	osc_monitor_pkg::power_state_e state;
	osc_monitor_pkg::power_state_e next_state;

	// wakeup timer
	logic [`RTC_W-1:0] rtc_cnt;
	logic [`RTC_W-1:0] next_rtc_cnt;
	logic next_rtc_running;
	logic next_rtc_wake;

	// tick chain
	logic src_tick; // undivided selected source
	logic [`SDD_W-1:0] presc_m1;
	logic [`SDD_W-1:0] sdd_m1;
	logic presc_tick;
	logic sdd_tick;
	logic sdd_active;

	// output next values
	logic next_cpu_clk_tick;
	logic next_periph_clk_tick;
	logic [`PERIPH_N-1:0] next_periph_clk_en;
	logic next_pll_enable;
	logic next_cpu_halted;
	logic next_clocks_stopped;
	logic [`PERIPH_N-1:0] group_off; // bits cleared by the group control

	// synchronisers run free, also during reset, so the strap is settled
	always_ff @(posedge clk_sys) begin
		osc_sync <= {osc_sync[1:0], crystal_input};
		pll_sync <= {pll_sync[1:0], pll_ref_clk};
		rd_sync <= {rd_sync[1:0], rd_strobe_n};
		xirq_sync <= {xirq_sync[1:0], ext_irq};
		// a change counts once stages two and three agree
		if (osc_sync[1] == osc_sync[2]) begin
			osc_level <= osc_sync[2];
		end
		if (pll_sync[1] == pll_sync[2]) begin
			pll_level <= pll_sync[2];
		end
		if (rd_sync[1] == rd_sync[2]) begin
			rd_level <= rd_sync[2];
		end
		if (xirq_sync[1] == xirq_sync[2]) begin
			xirq_level <= xirq_sync[2];
		end
		osc_prev <= osc_level;
		pll_prev <= pll_level;
		xirq_prev <= xirq_level;
	end

	// edge detection on filtered levels
	always_comb begin
		osc_edge = osc_level & ~osc_prev;
		pll_edge = pll_level & ~pll_prev;
		xirq_edge = xirq_level & ~xirq_prev;
	end

	// oscillator supervision, next values
	always_comb begin
		next_miss_cnt = miss_cnt;
		next_clock_fallback = clock_fallback;
		next_monitor_irq = 1'b0;
		next_monitor_disable = monitor_disable | monitor_disable_set;
		// armed only with PLL running and monitor enabled
		mon_active = pll_enable & ~monitor_disable & ~monitor_disable_set & ~clock_fallback
			& ((state == osc_monitor_pkg::PS_RUN) | (state == osc_monitor_pkg::PS_IDLE));
		if (osc_edge) begin
			// oscillator alive, restart the count
			next_miss_cnt = `MISS_RST;
		end else if (pll_edge && mon_active) begin
			if (miss_cnt == `OSC_MISS_LIMIT - 8'h01) begin
				// oscillator declared missing
				next_miss_cnt = `MISS_RST;
				next_clock_fallback = 1'b1;
				next_monitor_irq = 1'b1;
			end else begin
				next_miss_cnt = miss_cnt + 8'h01;
			end
		end
	end

	// oscillator supervision registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			miss_cnt <= `MISS_RST;
			clock_fallback <= 1'b0;
			monitor_irq <= 1'b0;
			// last value taken while reset is held is the strap
			monitor_disable <= ~rd_level;
		end else begin
			miss_cnt <= next_miss_cnt;
			clock_fallback <= next_clock_fallback;
			monitor_irq <= next_monitor_irq;
			monitor_disable <= next_monitor_disable;
		end
	end

	// power state transitions
	always_comb begin
		next_state = state;
		case (state)
			osc_monitor_pkg::PS_RUN: begin
				// power-down has priority over sleep over idle
				if (power_cmd.pdown) begin
					next_state = osc_monitor_pkg::PS_PDOWN;
				end else if (power_cmd.sleep) begin
					next_state = osc_monitor_pkg::PS_SLEEP;
				end else if (power_cmd.idle) begin
					next_state = osc_monitor_pkg::PS_IDLE;
				end
			end
			osc_monitor_pkg::PS_IDLE: begin
				// any interrupt resumes the CPU
				if (irq_pending || xirq_edge) begin
					next_state = osc_monitor_pkg::PS_RUN;
				end
			end
			osc_monitor_pkg::PS_SLEEP: begin
				// external interrupt or timer wakeup
				if (xirq_edge) begin
					next_state = osc_monitor_pkg::PS_RUN;
				end else if (rtc_wake) begin
					next_state = osc_monitor_pkg::PS_RUN;
				end
			end
			osc_monitor_pkg::PS_PDOWN: begin
				// left only through reset
				next_state = osc_monitor_pkg::PS_PDOWN;
			end
			default: begin
				next_state = osc_monitor_pkg::PS_RUN;
			end
		endcase
	end

	// power state register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= osc_monitor_pkg::PS_RUN;
		end else begin
			state <= next_state;
		end
	end

	// wakeup timer, next values
	always_comb begin
		next_rtc_cnt = rtc_cnt;
		next_rtc_wake = 1'b0;
		// runs while awake, in low power only if asked to keep running
		next_rtc_running = rtc_enable & (((state != osc_monitor_pkg::PS_SLEEP)
			& (state != osc_monitor_pkg::PS_PDOWN)) | rtc_keep_run);
		if (!rtc_running) begin
			next_rtc_cnt = `RTC_RST;
		end else if (rtc_cnt >= rtc_period) begin
			// period reached, cyclic wakeup pulse
			next_rtc_cnt = `RTC_RST;
			next_rtc_wake = 1'b1;
		end else begin
			next_rtc_cnt = rtc_cnt + 16'h0001;
		end
	end

	// wakeup timer registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rtc_cnt <= `RTC_RST;
			rtc_running <= 1'b0;
			rtc_wake <= 1'b0;
		end else begin
			rtc_cnt <= next_rtc_cnt;
			rtc_running <= next_rtc_running;
			rtc_wake <= next_rtc_wake;
		end
	end

	// source select and divider settings
	always_comb begin
		// PLL base clock replaces oscillator after fallback
		src_tick = clock_fallback ? pll_edge : osc_edge;
		// prescaler halves any source, direct drive passes it
		presc_m1 = clock_mgmt_reg.prescaler_mode ? `DIV_BY_2_M1 : `DIV_BY_1_M1;
		// slow-down acts on the oscillator only
		sdd_active = clock_mgmt_reg.sdd_enable & ~clock_fallback;
		sdd_m1 = sdd_active ? clock_mgmt_reg.sdd_factor_m1 : `DIV_BY_1_M1;
	end

	// prescaler stage
	tick_divider u_prescaler (
		.clk_sys(clk_sys),
		.reset(reset),
		.tick_in(src_tick),
		.div_m1(presc_m1),
		.tick_out(presc_tick)
	);

	// slow-down stage
	tick_divider u_slow_down_divider (
		.clk_sys(clk_sys),
		.reset(reset),
		.tick_in(presc_tick),
		.div_m1(sdd_m1),
		.tick_out(sdd_tick)
	);

	// output next values
	always_comb begin
		// CPU clock only in run
		next_cpu_clk_tick = sdd_tick & (state == osc_monitor_pkg::PS_RUN);
		next_cpu_halted = (state != osc_monitor_pkg::PS_RUN);
		// peripherals clocked in run and idle
		next_periph_clk_tick = sdd_tick & ((state == osc_monitor_pkg::PS_RUN)
			| (state == osc_monitor_pkg::PS_IDLE));
		next_clocks_stopped = (state == osc_monitor_pkg::PS_SLEEP)
			| (state == osc_monitor_pkg::PS_PDOWN);
		// group bit clears a whole block of enables
		group_off = peripheral_mgmt_reg.group_disable ? `PERIPH_GROUP_MASK : `PERIPH_EN_RST;
		if (next_clocks_stopped) begin
			next_periph_clk_en = `PERIPH_EN_RST;
		end else begin
			next_periph_clk_en = peripheral_mgmt_reg.enable & ~group_off;
		end
		// PLL off in sleep and power-down, else on after fallback, else idle when monitor disabled or switched off in slow-down
		if (next_clocks_stopped) begin
			next_pll_enable = 1'b0;
		end else if (clock_fallback) begin
			next_pll_enable = 1'b1;
		end else begin
			next_pll_enable = ~next_monitor_disable
				& ~(sdd_active & clock_mgmt_reg.pll_off_req);
		end
	end

	// output registers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cpu_clk_tick <= 1'b0;
			periph_clk_tick <= 1'b0;
			periph_clk_en <= `PERIPH_EN_RST;
			pll_enable <= 1'b0;
			cpu_halted <= 1'b0;
			clocks_stopped <= 1'b0;
		end else begin
			cpu_clk_tick <= next_cpu_clk_tick;
			periph_clk_tick <= next_periph_clk_tick;
			periph_clk_en <= next_periph_clk_en;
			pll_enable <= next_pll_enable;
			cpu_halted <= next_cpu_halted;
			clocks_stopped <= next_clocks_stopped;
		end
	end

endmodule : oscillator_monitor_power_control

// ---- rtl/tick_divider.sv ----
`timescale 1ns/1ps
`include "osc_monitor_defines.svh"

module tick_divider (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// incoming tick and division factor minus one
	input wire logic tick_in,
	input wire logic [`SDD_W-1:0] div_m1,
	// divided tick
	output logic tick_out
);

	logic [`SDD_W-1:0] count; // ticks seen in current period
	logic [`SDD_W-1:0] next_count;
	logic next_tick_out;

	// pass every (div_m1+1)-th input tick
	always_comb begin
		next_count = count;
		next_tick_out = 1'b0;
		if (tick_in) begin
			if (count >= div_m1) begin
				// period complete
				next_count = '0;
				next_tick_out = 1'b1;
			end else begin
				next_count = count + 5'h01;
			end
		end
	end

	// register state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count <= '0;
			tick_out <= 1'b0;
		end else begin
			count <= next_count;
			tick_out <= next_tick_out;
		end
	end

endmodule : tick_divider
